//--- hw/sacr_host.sv
// Host controller: starts conversions on the converter and reads its results
`timescale 1ns/1ps
module sacr_host (
  input  wire logic        sys_clk,             // 250 MHz system clock
  input  wire logic        rstn,                // Async reset, active low
  input  wire logic [3:0]  reg_addr,            // Register byte address
  input  wire logic [31:0] reg_wdata,           // Register write data
  input  wire logic        reg_wr,              // Write strobe
  input  wire logic        reg_rd,              // Read strobe
  output logic      [31:0] reg_rdata,           // Read data, cycle after strobe
  output logic             adc_reset,           // Converter reset, active high
  output logic             start_group_a,       // Start input A
  output logic             start_group_b,       // Start input B
  output logic             range_sel,           // High: wide range
  output logic             interface_select,    // High: serial interface
  output logic             cs_n,                // Chip select, active low
  output logic             rd_n,                // Read strobe / serial clock
  input  wire logic        busy,                // Converter busy
  input  wire logic        first_channel_flag,  // First channel marker
  input  wire logic [15:0] parallel_result_bus, // Parallel result lines
  input  wire logic        serial_line_a,       // Serial data line A
  input  wire logic        serial_line_b        // Serial data line B
);
  localparam int SW = 20;

  sacr_pkg::sacr_state_e     state_q;
  logic [SW-1:0]             s1_q;
  logic [SW-1:0]             s2_q;
  logic                      busy_s;
  logic                      flag_s;
  logic [15:0]               bus_s;
  logic                      line_a_s;
  logic                      line_b_s;
  logic [7:0]                cnt_q;
  logic [4:0]                bit_q;
  logic [2:0]                ch_q;
  logic [2:0]                half;
  logic [3:0]                nch_q;
  logic                      go_q;
  logic                      rst_req_q;
  logic                      range_cfg_q;
  logic                      serial_cfg_q;
  logic                      ferr_q;
  logic                      ferr_set;
  logic [15:0]               wa_q;
  logic [15:0]               wb_q;
  logic                      go_take;
  logic                      rst_take;
  logic                      data_rd;
  logic [7:0]                rstw_q;

  sacr_stream_if #(.W(sacr_pkg::WORD_W)) fill_s ();
  sacr_stream_if #(.W(sacr_pkg::WORD_W)) drain_s ();

  sacr_fifo #(.W(sacr_pkg::WORD_W), .D(sacr_pkg::FIFO_D)) u_fifo (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .in_s    (fill_s),
    .out_s   (drain_s)
  );

  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {busy, first_channel_flag, parallel_result_bus, serial_line_a, serial_line_b};
      s2_q <= s1_q;
    end
  end
  assign busy_s   = s2_q[19];
  assign flag_s   = s2_q[18];
  assign bus_s    = s2_q[17:2];
  assign line_a_s = s2_q[1];
  assign line_b_s = s2_q[0];

  assign half     = nch_q[3:1];
  assign go_take  = (state_q == sacr_pkg::S_IDLE) && go_q;
  assign rst_take = (state_q == sacr_pkg::S_IDLE) && !go_q && rst_req_q;
  assign data_rd  = reg_rd && (reg_addr == sacr_pkg::OFS_DATA);

  // Stream words; serial line B carries the upper half of the channels
  assign fill_s.valid = (state_q == sacr_pkg::S_PUSHA) || (state_q == sacr_pkg::S_PUSHB);
  assign fill_s.data  = (state_q == sacr_pkg::S_PUSHB) ? {ch_q + half, wb_q} : {ch_q, wa_q};
  assign drain_s.ready = data_rd;

  // Flag must be high exactly on channel one's read
  assign ferr_set = ((state_q == sacr_pkg::S_PRD) && (cnt_q == sacr_pkg::RDLOW_CYC)
                     && (flag_s != (ch_q == '0)))
                 || ((state_q == sacr_pkg::S_SLO) && (cnt_q == sacr_pkg::SCLKH_CYC)
                     && (bit_q == '0) && (flag_s != (ch_q == '0)));

  // Software registers; a pending request set wins over its consumption
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      go_q         <= 1'b0;
      rst_req_q    <= 1'b0;
      range_cfg_q  <= 1'b0;
      serial_cfg_q <= 1'b0;
      nch_q        <= sacr_pkg::NCH_RST;
      ferr_q       <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == sacr_pkg::OFS_CTRL) begin
        go_q         <= reg_wdata[sacr_pkg::CTRL_GO] | (go_q & ~go_take);
        rst_req_q    <= reg_wdata[sacr_pkg::CTRL_RESET] | (rst_req_q & ~rst_take);
        range_cfg_q  <= reg_wdata[sacr_pkg::CTRL_RANGE];
        serial_cfg_q <= reg_wdata[sacr_pkg::CTRL_SERIAL];
      end else begin
        go_q      <= go_q & ~go_take;
        rst_req_q <= rst_req_q & ~rst_take;
      end
      if (reg_wr && reg_addr == sacr_pkg::OFS_NCH) begin
        nch_q <= (reg_wdata[3:0] == '0 || reg_wdata[3:0] > sacr_pkg::NCH_RST)
                 ? sacr_pkg::NCH_RST : reg_wdata[3:0];
      end
      if (ferr_set) begin
        ferr_q <= 1'b1;
      end else if (reg_wr && reg_addr == sacr_pkg::OFS_STATUS && reg_wdata[sacr_pkg::ST_FERR_B]) begin
        ferr_q <= 1'b0;
      end
    end
  end

  // Read port; a data read pops the FIFO, empty reads give zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        sacr_pkg::OFS_CTRL:   reg_rdata <= {28'h0000000, serial_cfg_q, range_cfg_q, rst_req_q, go_q};
        sacr_pkg::OFS_NCH:    reg_rdata <= {28'h0000000, nch_q};
        sacr_pkg::OFS_STATUS: reg_rdata <= {28'h0000000, ferr_q, drain_s.valid, busy_s,
                                            state_q == sacr_pkg::S_IDLE};
        sacr_pkg::OFS_DATA:   reg_rdata <= drain_s.valid ? {13'h0000, drain_s.data} : '0;
        default:              reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Sequencer: reset pulse, start, wait on busy, then read the channels; serial mode reads whole A/B pairs only, so an odd count above one drops its last
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q          <= sacr_pkg::S_RST;
      cnt_q            <= '0;
      bit_q            <= '0;
      ch_q             <= '0;
      wa_q             <= '0;
      wb_q             <= '0;
      adc_reset        <= 1'b1;
      start_group_a    <= 1'b0;
      start_group_b    <= 1'b0;
      range_sel        <= 1'b0;
      interface_select <= 1'b0;
      cs_n             <= 1'b1;
      rd_n             <= 1'b1;
    end else begin
      case (state_q)
        sacr_pkg::S_RST: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == sacr_pkg::RST_CYC - 8'h01) begin
            adc_reset <= 1'b0;
            cnt_q     <= '0;
            state_q   <= sacr_pkg::S_IDLE;
          end
        end
        sacr_pkg::S_IDLE: begin
          // Range and mode only move between conversions
          range_sel        <= range_cfg_q;
          interface_select <= serial_cfg_q;
          cnt_q            <= '0;
          if (go_take && !busy_s) begin
            start_group_a <= 1'b1;
            start_group_b <= 1'b1;
            state_q       <= sacr_pkg::S_START;
          end else if (rst_take) begin
            adc_reset <= 1'b1;
            state_q   <= sacr_pkg::S_RST;
          end
        end
        sacr_pkg::S_START: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == sacr_pkg::START_CYC - 8'h01) begin
            start_group_a <= 1'b0;
            start_group_b <= 1'b0;
            state_q       <= sacr_pkg::S_WBH;
          end
        end
        sacr_pkg::S_WBH: begin
          if (busy_s) begin
            state_q <= sacr_pkg::S_WBL;
          end
        end
        sacr_pkg::S_WBL: begin
          cnt_q <= '0;
          if (!busy_s) begin
            state_q <= sacr_pkg::S_LATCH;
          end
        end
        sacr_pkg::S_LATCH: begin
          // Results settle a short time after busy falls
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == sacr_pkg::LATCH_CYC) begin
            cnt_q   <= '0;
            ch_q    <= '0;
            bit_q   <= '0;
            cs_n    <= 1'b0;
            rd_n    <= serial_cfg_q ? 1'b1 : 1'b0;
            state_q <= serial_cfg_q ? sacr_pkg::S_SHI : sacr_pkg::S_PRD;
          end
        end
        sacr_pkg::S_PRD: begin
          // Counted past sync latency so the bus is stable when taken
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == sacr_pkg::RDLOW_CYC) begin
            wa_q    <= bus_s;
            cs_n    <= 1'b1;
            rd_n    <= 1'b1;
            state_q <= sacr_pkg::S_PUSHA;
          end
        end
        sacr_pkg::S_SHI: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == sacr_pkg::SCLKH_CYC) begin
            cnt_q   <= '0;
            rd_n    <= 1'b0;
            state_q <= sacr_pkg::S_SLO;
          end
        end
        sacr_pkg::S_SLO: begin
          // Sample just before the rising edge that shifts the next bit
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == sacr_pkg::SCLKH_CYC) begin
            cnt_q <= '0;
            wa_q  <= {wa_q[14:0], line_a_s};
            wb_q  <= {wb_q[14:0], line_b_s};
            rd_n  <= 1'b1;
            bit_q <= bit_q + 1'b1;
            if (bit_q == sacr_pkg::LAST_BIT) begin
              cs_n    <= 1'b1;
              state_q <= sacr_pkg::S_PUSHA;
            end else begin
              state_q <= sacr_pkg::S_SHI;
            end
          end
        end
        sacr_pkg::S_PUSHA: begin
          // Full FIFO stalls the read sequence here
          cnt_q <= '0;
          bit_q <= '0;
          if (fill_s.ready) begin
            if (interface_select) begin
              state_q <= sacr_pkg::S_PUSHB;
            end else if ({1'b0, ch_q} + 4'h1 == nch_q) begin
              state_q <= sacr_pkg::S_IDLE;
            end else begin
              ch_q    <= ch_q + 1'b1;
              cs_n    <= 1'b0;
              rd_n    <= 1'b0;
              state_q <= sacr_pkg::S_PRD;
            end
          end
        end
        sacr_pkg::S_PUSHB: begin
          if (fill_s.ready) begin
            if (ch_q + 3'h1 >= half) begin
              state_q <= sacr_pkg::S_IDLE;
            end else begin
              ch_q    <= ch_q + 1'b1;
              cs_n    <= 1'b0;
              state_q <= sacr_pkg::S_SHI;
            end
          end
        end
        default: begin
          cs_n    <= 1'b1;
          rd_n    <= 1'b1;
          state_q <= sacr_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Helper: width of the current reset pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstw_q <= '0;
    end else begin
      rstw_q <= adc_reset ? rstw_q + 1'b1 : '0;
    end
  end

  property p_starts_together;
    @(posedge sys_clk) disable iff (!rstn)
      start_group_a == start_group_b;
  endproperty
  a_starts_together: assert property (p_starts_together)
    else $error("start pins differ");

  property p_start_not_busy;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(start_group_a) |-> !busy_s ##1 start_group_a [*8];
  endproperty
  a_start_not_busy: assert property (p_start_not_busy)
    else $error("start raised while busy or too short");

  property p_reset_width;
    @(posedge sys_clk) disable iff (!rstn)
      $fell(adc_reset) |-> rstw_q == sacr_pkg::RST_CYC;
  endproperty
  a_reset_width: assert property (p_reset_width)
    else $error("reset pulse width wrong");

  property p_no_read_busy;
    @(posedge sys_clk) disable iff (!rstn)
      !cs_n |-> !busy_s;
  endproperty
  a_no_read_busy: assert property (p_no_read_busy)
    else $error("read overlaps busy");

  property p_range_idle;
    @(posedge sys_clk) disable iff (!rstn)
      $changed(range_sel) |-> $past(state_q) == sacr_pkg::S_IDLE;
  endproperty
  a_range_idle: assert property (p_range_idle)
    else $error("range changed outside idle");
endmodule // sacr_host

//--- hw/sacr_pkg.sv
// Shared constants for the converter host controller
package sacr_pkg;
  // Clock and pin timing, times in ns, counts derived at 250 MHz
  localparam int CLK_PS       = 4000;
  localparam int T_RESET_NS   = 50;   // Reset pulse width
  localparam int T_START_NS   = 40;   // Start pulse high time
  localparam int T_LATCH_NS   = 40;   // Wait after busy falls before reading
  localparam int T_RDLOW_NS   = 40;   // Read strobe low time, parallel
  localparam int T_SCLKH_NS   = 40;   // Half period of generated serial clock
  localparam int RST_CYC_I    = (T_RESET_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int START_CYC_I  = (T_START_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int LATCH_CYC_I  = (T_LATCH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RDLOW_CYC_I  = (T_RDLOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SCLKH_CYC_I  = (T_SCLKH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [7:0] RST_CYC   = 8'(RST_CYC_I);
  localparam logic [7:0] START_CYC = 8'(START_CYC_I);
  localparam logic [7:0] LATCH_CYC = 8'(LATCH_CYC_I);
  localparam logic [7:0] RDLOW_CYC = 8'(RDLOW_CYC_I);
  localparam logic [7:0] SCLKH_CYC = 8'(SCLKH_CYC_I);

  // Result layout and stream width
  localparam int RES_W  = 16;
  localparam int CH_W   = 3;
  localparam int WORD_W = RES_W + CH_W;
  localparam int FIFO_D = 4;
  localparam logic [4:0] LAST_BIT = 5'h0F;

  // Register map of the controller
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_NCH    = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_DATA   = 4'hC;
  localparam int CTRL_GO     = 0;
  localparam int CTRL_RESET  = 1;
  localparam int CTRL_RANGE  = 2;
  localparam int CTRL_SERIAL = 3;
  localparam int ST_IDLE_B   = 0;
  localparam int ST_BUSY_B   = 1;
  localparam int ST_AVAIL_B  = 2;
  localparam int ST_FERR_B   = 3;
  localparam logic [3:0] NCH_RST = 4'h8;

  // Sequencer states
  typedef enum logic [11:0] {
    S_RST   = 12'h001,
    S_IDLE  = 12'h002,
    S_START = 12'h004,
    S_WBH   = 12'h008,
    S_WBL   = 12'h010,
    S_LATCH = 12'h020,
    S_PRD   = 12'h040,
    S_SHI   = 12'h080,
    S_SLO   = 12'h100,
    S_PUSHA = 12'h200,
    S_PUSHB = 12'h400,
    S_SPARE = 12'h800
  } sacr_state_e;
endpackage

//--- hw/sacr_stream_if.sv
// Valid/ready stream carrier between controller and its FIFO
`timescale 1ns/1ps
interface sacr_stream_if #(parameter int W = 19);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- hw/sacr_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sacr_fifo #(
  parameter int W = 19,
  parameter int D = 4
) (
  input wire logic sys_clk,      // System clock
  input wire logic rstn,         // Async reset, active low
  sacr_stream_if.snk in_s,       // Fill side
  sacr_stream_if.src out_s       // Drain side
);
  localparam int PW = $clog2(D);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(D);
  localparam logic [PW-1:0] LAST_IX = PW'(D - 1);

  logic [W-1:0]  mem_q [D];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Honest flags; full drops ready so the producer stalls
  assign in_s.ready  = (cnt_q != FULL_CNT);
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rp_q];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // Storage, written by index
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == LAST_IX) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == LAST_IX) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // sacr_fifo

//--- verif/sacr_dev_model.sv
// Behavioural model of the converter as seen from the host controller
`timescale 1ns/1ps
module sacr_dev_model #(
  parameter int CONV = 100 // Conversion time in model clock cycles
) (
  input  wire logic        clk,       // Model sampling clock
  input  wire logic        adc_reset, // Reset pin
  input  wire logic        start_a,   // Start pin A
  input  wire logic        start_b,   // Start pin B
  input  wire logic        range_sel, // Range pin
  input  wire logic        ser,       // Interface select pin
  input  wire logic        cs_n,      // Chip select
  input  wire logic        rd_n,      // Read strobe / serial clock
  input  wire logic        bad_flag,  // Test hook: wrong flag level
  output logic             busy,      // Busy pin
  output logic             flag,      // First channel flag
  output logic      [15:0] bus,       // Parallel result bus
  output logic             sa,        // Serial line A
  output logic             sb         // Serial line B
);
  logic [15:0] res [8];
  logic [7:0]  nconv, cnt;
  logic [3:0]  bitn, fcnt;
  logic [2:0]  idx;
  logic        ga, gb, ra, rb, pa, pb, pr, pc, pd;

  initial begin
    {busy, flag, sa, sb, ga, gb, ra, rb, pa, pb, pr} = 11'h000;
    {pc, pd} = 2'h3;
    {bus, nconv, cnt, bitn, fcnt, idx} = 43'h0;
  end

  // Pins sampled each cycle; released lines toggle so stale data never passes
  always @(posedge clk) begin
    {pa, pb, pr, pc, pd} <= {start_a, start_b, adc_reset, cs_n, rd_n};
    if (!ser && !cs_n && !rd_n) bus <= res[idx];
    else bus <= ~bus;
    if (cs_n) flag <= ~flag;
    else if (ser && pc) begin
      flag <= (idx == 3'h0) ^ bad_flag;
      fcnt <= 4'h0;
    end else if (!rd_n && pd) begin
      if (ser) begin
        fcnt <= fcnt + 4'h1;
        if (fcnt == 4'hF) flag <= 1'b0;
      end else flag <= (idx == 3'h0) ^ bad_flag;
    end
    if (cs_n) begin
      sa <= ~sa;
      sb <= ~sb;
    end else if (ser && pc) begin
      bitn <= 4'hF;
      sa   <= res[idx][15];
      sb   <= res[idx + 3'h4][15];
    end else if (ser && rd_n && !pd) begin
      bitn <= bitn - 4'h1;
      sa   <= res[idx][bitn - 4'h1];
      sb   <= res[idx + 3'h4][bitn - 4'h1];
    end
    if (cs_n && !pc) idx <= idx + 3'h1;
    // Conversion last so that reset wins over everything above
    if (adc_reset && !pr) begin
      busy <= 1'b0;
      {ga, gb, idx} <= 5'h00;
      for (int k = 0; k < 8; k++) res[k] <= 16'h0000;
    end else if (!busy) begin
      if (start_a && !pa) {ga, ra} <= {1'b1, range_sel};
      if (start_b && !pb) {gb, rb} <= {1'b1, range_sel};
      if (ga && gb) begin
        busy <= 1'b1;
        cnt  <= 8'(CONV);
        {ga, gb} <= 2'h0;
      end
    end else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    else begin
      busy  <= 1'b0;
      idx   <= 3'h0;
      nconv <= nconv + 8'h01;
      for (int k = 0; k < 8; k++)
        res[k] <= {((k < 4) ? ra : rb) ? 4'hC : 4'h3, 4'(k), nconv + 8'h01};
    end
  end
endmodule // sacr_dev_model

//--- verif/test_sacr_host.sv
// Self-checking bench of the converter host controller
`timescale 1ns/1ps
module test_sacr_host;
  logic        sys_clk, rstn, reg_wr, reg_rd, adc_reset, start_group_a, start_group_b;
  logic        range_sel, interface_select, cs_n, rd_n, busy, flag, sa, sb, bad_flag, rng_q;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] bus;
  logic [7:0]  nconv;
  int          fails, tests_run;

  sacr_host sacr_host_i (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_reset(adc_reset), .start_group_a(start_group_a), .start_group_b(start_group_b),
    .range_sel(range_sel), .interface_select(interface_select), .cs_n(cs_n), .rd_n(rd_n),
    .busy(busy), .first_channel_flag(flag), .parallel_result_bus(bus),
    .serial_line_a(sa), .serial_line_b(sb));
  sacr_dev_model sacr_dev_model_i (.clk(sys_clk), .adc_reset(adc_reset),
    .start_a(start_group_a), .start_b(start_group_b), .range_sel(range_sel),
    .ser(interface_select), .cs_n(cs_n), .rd_n(rd_n), .bad_flag(bad_flag), .busy(busy),
    .flag(flag), .bus(bus), .sa(sa), .sb(sb));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Bounded poll of one status bit
  task automatic wait_st(input int b);
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < 3000 && s[b] !== 1'b1; i++) rd(sacr_pkg::OFS_STATUS, s);
    chk("status wait", 32'(s[b]), 32'h1);
  endtask

  // Reset pulse measured in ns, optionally requested by software
  task automatic rst_width(input bit ask);
    realtime t0;
    if (ask) wr(sacr_pkg::OFS_CTRL, 32'h2);
    for (int i = 0; i < 50 && adc_reset !== 1'b1; i++) tick();
    t0 = $realtime;
    for (int i = 0; i < 50 && adc_reset !== 1'b0; i++) tick();
    chk("reset width", 32'($realtime - t0 >= 50.0 && $realtime - t0 <= 60.0), 32'h1);
  endtask

  // One conversion, left to stall on a full FIFO when more than four channels, then drained in order
  task automatic run(input logic [31:0] ctl, input int nch, input bit ser);
    logic [31:0] s;
    int          ch;
    wr(sacr_pkg::OFS_NCH, 32'(nch));
    wr(sacr_pkg::OFS_CTRL, ctl);
    nconv++;
    repeat (1000) @(posedge sys_clk);
    rd(sacr_pkg::OFS_STATUS, s);
    if (nch > 4) chk("fifo full", 32'({s[2], s[0]}), 32'h2);
    for (int i = 0; i < nch; i++) begin
      ch = ser ? (i / 2 + (i % 2) * 4) : i;
      wait_st(sacr_pkg::ST_AVAIL_B);
      rd(sacr_pkg::OFS_DATA, s);
      chk("data", s, {13'h0, 3'(ch), ctl[2] ? 4'hC : 4'h3, 4'(ch), nconv});
    end
    wait_st(sacr_pkg::ST_IDLE_B);
    rd(sacr_pkg::OFS_DATA, s);
    chk("empty read", s, 32'h0);
    rd(sacr_pkg::OFS_STATUS, s);
    chk("flag state", 32'(s[sacr_pkg::ST_FERR_B]), 32'(bad_flag));
    chk("range pin", 32'(range_sel), 32'(ctl[2]));
    chk("mode pin", 32'(interface_select), 32'(ctl[3]));
    $display("test conversion %h done", ctl);
  endtask

  // Pin-level watch of the host's own obligations
  always @(posedge sys_clk) begin
    rng_q <= range_sel;
    if (rstn && start_group_a !== start_group_b) chk("starts apart", 32'h1, 32'h0);
    if (rstn && busy && !cs_n) chk("read in busy", 32'h1, 32'h0);
    if (rstn && busy && range_sel !== rng_q) chk("range in busy", 32'h1, 32'h0);
  end

  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Run budget is far above the expected five thousand cycles
  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    {rstn, reg_wr, reg_rd, bad_flag, rng_q} = 5'h00;
    {reg_addr, reg_wdata, nconv, fails, tests_run} = 108'h0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    rst_width(1'b0);
    rd(sacr_pkg::OFS_NCH, d);
    chk("nch reset", d, 32'(sacr_pkg::NCH_RST));
    rd(4'h2, d);
    chk("unmapped", d, 32'h0);
    chk("idle pins", 32'({cs_n, rd_n}), 32'h3);
    $display("test reset done");
    run(32'h5, 8, 1'b0);
    run(32'h9, 8, 1'b1);
    wr(sacr_pkg::OFS_NCH, 32'h0);
    rd(sacr_pkg::OFS_NCH, d);
    chk("nch zero", d, 32'h8);
    wr(sacr_pkg::OFS_NCH, 32'h9);
    rd(sacr_pkg::OFS_NCH, d);
    chk("nch nine", d, 32'h8);
    run(32'h1, 3, 1'b0);
    rst_width(1'b1);
    bad_flag <= 1'b1;
    run(32'h1, 1, 1'b0);
    bad_flag <= 1'b0;
    rd(sacr_pkg::OFS_STATUS, d);
    chk("flag error", 32'(d[sacr_pkg::ST_FERR_B]), 32'h1);
    wr(sacr_pkg::OFS_STATUS, 32'h8);
    rd(sacr_pkg::OFS_STATUS, d);
    chk("flag clear", 32'(d[sacr_pkg::ST_FERR_B]), 32'h0);
    $display("test flag error done");
    results();
  end
endmodule // test_sacr_host
